// ==== design/dpr_top.v ====
// dual-ported 2 Kbyte data ram: core port and dma port, no wait states
// assumes both requesters run on ref_clk; addresses are byte addresses
`timescale 1ns/100ps
`default_nettype none
`include "dpr_consts.vh"
module dpr_top (
  input  wire                    ref_clk,   // system clock, 200 MHz
  input  wire                    rst_n,     // async reset, active low
  input  wire                    cpu_en,    // core access request
  input  wire                    cpu_wr,    // core write when high
  input  wire                    cpu_byte,  // core byte access
  input  wire [`DPR_ADDR_W-1:0]  cpu_addr,  // core byte address
  input  wire [`DPR_DATA_W-1:0]  cpu_wdata, // core write data
  output reg  [`DPR_DATA_W-1:0]  cpu_rdata, // core read data
  output reg                     cpu_rvld,  // core read data valid
  input  wire                    dma_en,    // dma access request
  input  wire                    dma_wr,    // dma write when high
  input  wire                    dma_byte,  // dma byte access
  input  wire [`DPR_ADDR_W-1:0]  dma_addr,  // dma byte address
  input  wire [`DPR_DATA_W-1:0]  dma_wdata, // dma write data
  output reg  [`DPR_DATA_W-1:0]  dma_rdata, // dma read data
  output reg                     dma_rvld   // dma read data valid
);
  // ==========================================================
  // request decode shared by both ports: a request with the write
  // strobe low is a read, answered on the edge after the one that takes it
  function rdreq;
    input en;
    input wr;
    begin
      rdreq = en && !wr;
    end
  endfunction

  // byte lane of an address: even picks the low lane, odd the high
  function lane_bit;
    input [`DPR_ADDR_W-1:0] ad;
    begin
      lane_bit = ad[`DPR_LANE_BIT];
    end
  endfunction

  // word index: bits above the 1024-word range are dropped, since the
  // system decoder alone places the block at the top of Y space
  function [`DPR_WADDR_W-1:0] word_idx;
    input [`DPR_ADDR_W-1:0] ad;
    begin
      word_idx = ad[`DPR_WADDR_MSB:`DPR_WADDR_LSB];
    end
  endfunction

  // lane decode shared by both ports; a word access ignores the lane
  // bit, and a misaligned word is not trapped here
  function [1:0] lanes;
    input en;
    input wr;
    input bt;
    input a0;
    begin
      if (!(en && wr))
        lanes = `DPR_LANES_NONE;
      else if (bt)
        lanes = a0 ? `DPR_LANES_HI : `DPR_LANES_LO;
      else
        lanes = `DPR_LANES_ALL;
    end
  endfunction

  // byte data is placed on both lanes; enables pick the one written
  function [`DPR_DATA_W-1:0] wdat;
    input bt;
    input [`DPR_DATA_W-1:0] d;
    begin
      wdat = bt ? {d[`DPR_BYTE_W-1:0], d[`DPR_BYTE_W-1:0]} : d;
    end
  endfunction

  // read side: byte read returns the selected byte in the low lane
  function [`DPR_DATA_W-1:0] rsel;
    input bt;
    input a0;
    input [`DPR_DATA_W-1:0] w;
    begin
      if (!bt)
        rsel = w;
      else if (a0)
        rsel = {`DPR_ZERO8, w[`DPR_DATA_W-1:`DPR_BYTE_W]};
      else
        rsel = {`DPR_ZERO8, w[`DPR_BYTE_W-1:0]};
    end
  endfunction

  // ==========================================================
  // internal nets and registers
  wire [`DPR_WADDR_W-1:0] cpu_wa;
  wire [`DPR_WADDR_W-1:0] dma_wa;
  wire [1:0]              cpu_we;
  wire [1:0]              dma_we;
  wire [`DPR_DATA_W-1:0]  cpu_wd;
  wire [`DPR_DATA_W-1:0]  dma_wd;
  wire [`DPR_DATA_W-1:0]  cpu_word;
  wire [`DPR_DATA_W-1:0]  dma_word;
  reg                     cpu_rd_r;
  reg                     cpu_bt_r;
  reg                     cpu_a0_r;
  reg                     dma_rd_r;
  reg                     dma_bt_r;
  reg                     dma_a0_r;
  reg                     cpu_rd_nxt;
  reg                     cpu_bt_nxt;
  reg                     cpu_a0_nxt;
  reg                     dma_rd_nxt;
  reg                     dma_bt_nxt;
  reg                     dma_a0_nxt;
  reg                     cpu_rvld_nxt;
  reg                     dma_rvld_nxt;
  reg  [`DPR_DATA_W-1:0]  cpu_rdata_nxt;
  reg  [`DPR_DATA_W-1:0]  dma_rdata_nxt;

  // ==========================================================
  // address decode and write strobes; byte data is copied to both
  // lanes and the strobes pick the one that is written
  assign cpu_wa = word_idx(cpu_addr);
  assign dma_wa = word_idx(dma_addr);
  assign cpu_we = lanes(cpu_en, cpu_wr, cpu_byte,
                        lane_bit(cpu_addr));
  assign dma_we = lanes(dma_en, dma_wr, dma_byte,
                        lane_bit(dma_addr));
  assign cpu_wd = wdat(cpu_byte, cpu_wdata);
  assign dma_wd = wdat(dma_byte, dma_wdata);

  // ==========================================================
  // storage: core on port a so it wins a same-location write; the
  // dma port has its own address and data path, so it never waits
  dpr_mem u_mem (
    .ref_clk (ref_clk),
    .a_addr  (cpu_wa),
    .a_we    (cpu_we),
    .a_wd    (cpu_wd),
    .a_rd    (cpu_word),
    .b_addr  (dma_wa),
    .b_we    (dma_we),
    .b_wd    (dma_wd),
    .b_rd    (dma_word)
  );

  // ==========================================================
  // stage 1, core: the store registers its read, so the attributes
  // are delayed by the same one edge to meet the word
  always @* begin
    cpu_rd_nxt = rdreq(cpu_en, cpu_wr);
    cpu_bt_nxt = cpu_byte;
    cpu_a0_nxt = lane_bit(cpu_addr);
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rd_r <= `DPR_ZERO1;
      cpu_bt_r <= `DPR_ZERO1;
      cpu_a0_r <= `DPR_ZERO1;
    end else begin
      cpu_rd_r <= cpu_rd_nxt;
      cpu_bt_r <= cpu_bt_nxt;
      cpu_a0_r <= cpu_a0_nxt;
    end
  end

  // ==========================================================
  // stage 1, dma: same pipeline, no shared state with the core
  always @* begin
    dma_rd_nxt = rdreq(dma_en, dma_wr);
    dma_bt_nxt = dma_byte;
    dma_a0_nxt = lane_bit(dma_addr);
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_rd_r <= `DPR_ZERO1;
      dma_bt_r <= `DPR_ZERO1;
      dma_a0_r <= `DPR_ZERO1;
    end else begin
      dma_rd_r <= dma_rd_nxt;
      dma_bt_r <= dma_bt_nxt;
      dma_a0_r <= dma_a0_nxt;
    end
  end

  // ==========================================================
  // stage 2, core: data holds until the next read answer so a slow
  // consumer may pick it up late; valid lasts one cycle only
  always @* begin
    cpu_rvld_nxt  = cpu_rd_r;
    cpu_rdata_nxt = cpu_rdata;
    if (cpu_rd_r)
      cpu_rdata_nxt = rsel(cpu_bt_r, cpu_a0_r, cpu_word);
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= `DPR_ZERO16;
      cpu_rvld  <= `DPR_ZERO1;
    end else begin
      cpu_rdata <= cpu_rdata_nxt;
      cpu_rvld  <= cpu_rvld_nxt;
    end
  end

  // ==========================================================
  // stage 2, dma: answers in the same cycle count as the core
  always @* begin
    dma_rvld_nxt  = dma_rd_r;
    dma_rdata_nxt = dma_rdata;
    if (dma_rd_r)
      dma_rdata_nxt = rsel(dma_bt_r, dma_a0_r, dma_word);
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_rdata <= `DPR_ZERO16;
      dma_rvld  <= `DPR_ZERO1;
    end else begin
      dma_rdata <= dma_rdata_nxt;
      dma_rvld  <= dma_rvld_nxt;
    end
  end
endmodule // dpr_top
`default_nettype wire

// ==== design/dpr_consts.vh ====
// constants for the dual-ported dma ram block
// assumes one clock and one active-low asynchronous reset
//
// Behaviour
// - 2 Kbyte memory at top of Y data space, shared by core and DMA.
// - two independent ports; both may access in the same cycle.
// - DMA accesses never stall the core; core access always completes.
// - same-location writes in one cycle: core data wins.
// - 16-bit words, byte addresses; even selects low byte, odd high byte.
// - byte write updates only the lane picked by address bit zero.
`ifndef DPR_CONSTS_VH
`define DPR_CONSTS_VH
`define DPR_DATA_W    16
`define DPR_BYTE_W    8
`define DPR_ADDR_W    16
`define DPR_WADDR_W   10
`define DPR_WADDR_LSB 1
`define DPR_WADDR_MSB 10
`define DPR_DEPTH     1024
`define DPR_ZERO16    16'h0000
`define DPR_ZERO8     8'h00
`define DPR_ZERO1     1'h0
`define DPR_LANE_BIT  0
`define DPR_LO_LANE   0
`define DPR_HI_LANE   1
`define DPR_LANES_NONE 2'h0
`define DPR_LANES_LO  2'h1
`define DPR_LANES_HI  2'h2
`define DPR_LANES_ALL 2'h3
`endif

// ==== design/dpr_mem.v ====
// dual-port word memory with byte-lane write enables, registered reads
// assumes both ports are on one clock; port a has write priority
`timescale 1ns/100ps
`default_nettype none
`include "dpr_consts.vh"
module dpr_mem (
  input  wire                      ref_clk, // system clock
  input  wire [`DPR_WADDR_W-1:0]   a_addr,  // port a word address
  input  wire [1:0]                a_we,    // port a lane enables
  input  wire [`DPR_DATA_W-1:0]    a_wd,    // port a write data
  output reg  [`DPR_DATA_W-1:0]    a_rd,    // port a read data
  input  wire [`DPR_WADDR_W-1:0]   b_addr,  // port b word address
  input  wire [1:0]                b_we,    // port b lane enables
  input  wire [`DPR_DATA_W-1:0]    b_wd,    // port b write data
  output reg  [`DPR_DATA_W-1:0]    b_rd     // port b read data
);
  reg  [`DPR_BYTE_W-1:0] lo_mem [0:`DPR_DEPTH-1];
  reg  [`DPR_BYTE_W-1:0] hi_mem [0:`DPR_DEPTH-1];
  wire                   same_w;
  assign same_w = (a_addr == b_addr);

  // ==========================================================
  // writes: a lane of port b is dropped when port a hits it too
  always @(posedge ref_clk) begin
    if (a_we[`DPR_LO_LANE])
      lo_mem[a_addr] <= a_wd[`DPR_BYTE_W-1:0];
    else if (b_we[`DPR_LO_LANE])
      lo_mem[b_addr] <= b_wd[`DPR_BYTE_W-1:0];
    if (b_we[`DPR_LO_LANE] && a_we[`DPR_LO_LANE] && !same_w)
      lo_mem[b_addr] <= b_wd[`DPR_BYTE_W-1:0];
    if (a_we[`DPR_HI_LANE])
      hi_mem[a_addr] <= a_wd[`DPR_DATA_W-1:`DPR_BYTE_W];
    else if (b_we[`DPR_HI_LANE])
      hi_mem[b_addr] <= b_wd[`DPR_DATA_W-1:`DPR_BYTE_W];
    if (b_we[`DPR_HI_LANE] && a_we[`DPR_HI_LANE] && !same_w)
      hi_mem[b_addr] <= b_wd[`DPR_DATA_W-1:`DPR_BYTE_W];
    a_rd <= {hi_mem[a_addr], lo_mem[a_addr]};
    b_rd <= {hi_mem[b_addr], lo_mem[b_addr]};
  end
endmodule // dpr_mem
`default_nettype wire

// ==== testbench/dpr_chk.sv ====
// checker for the dual-ported ram: ties read answers to requests
// assumes it is bound to dpr_top, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// checker
module dpr_chk (
  input wire logic        ref_clk,   // clock
  input wire logic        rst_n,     // reset
  input wire logic        cpu_en,    // core req
  input wire logic        cpu_wr,    // core write
  input wire logic        cpu_byte,  // core byte
  input wire logic [15:0] cpu_addr,  // core addr
  input wire logic [15:0] cpu_wdata, // core wdata
  input wire logic [15:0] cpu_rdata, // core rdata
  input wire logic        cpu_rvld,  // core valid
  input wire logic        dma_en,    // dma req
  input wire logic        dma_wr,    // dma write
  input wire logic        dma_byte,  // dma byte
  input wire logic [15:0] dma_addr,  // dma addr
  input wire logic [15:0] dma_wdata, // dma wdata
  input wire logic [15:0] dma_rdata, // dma rdata
  input wire logic        dma_rvld   // dma valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic cr = cpu_en & ~cpu_wr;
  wire logic dr = dma_en & ~dma_wr;
  wire logic cw = cpu_en & cpu_wr & ~cpu_byte;
  wire logic dw = dma_en & dma_wr & ~dma_byte;
  wire logic hit = cpu_addr[10:1] == dma_addr[10:1];
  AST_CPU_ANS: assert property (cr |-> ##2 cpu_rvld)
    else $error("core read not answered");
  AST_DMA_ANS: assert property (dr |-> ##2 dma_rvld)
    else $error("dma read not answered");
  AST_CPU_QUIET: assert property (!cr |-> ##2 !cpu_rvld)
    else $error("core valid without read");
  AST_CPU_ZX: assert property (cr && cpu_byte |-> ##2 !cpu_rdata[15:8])
    else $error("core byte read upper not zero");
  AST_DMA_ZX: assert property (dr && dma_byte |-> ##2 !dma_rdata[15:8])
    else $error("dma byte read upper not zero");
  AST_CPU_WIN: assert property (
    cw ##1 cr && !cpu_byte && cpu_addr[10:1] == $past(cpu_addr[10:1])
    |-> ##2 cpu_rdata == $past(cpu_wdata, 3))
    else $error("core write lost");
  AST_DMA_WR: assert property (
    dw && !(cpu_en && cpu_wr && hit) ##1 dr && !dma_byte &&
    dma_addr[10:1] == $past(dma_addr[10:1])
    |-> ##2 dma_rdata == $past(dma_wdata, 3))
    else $error("dma write lost");
  cover property (cr && dr);
  cover property (cw && dw && hit);
  cover property (cr && cpu_byte);
endmodule // dpr_chk
bind dpr_top dpr_chk chk_u (.*);
`default_nettype wire

// ==== testbench/dpr_dma_mdl.sv ====
// dma controller side model: one request per call, no ready
// assumes calls are made at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// dma model
module dpr_dma_mdl (
  input  wire logic        clk, // clock
  output var  logic        en,  // request
  output var  logic        wr,  // write
  output var  logic        bt,  // byte
  output var  logic [15:0] a,   // address
  output var  logic [15:0] d    // write data
);
  initial {en, wr, bt, a, d} = 35'h0;
  // reads fetch outbound data, writes store inbound data
  task automatic put(input logic w, b, input logic [15:0] ad, dd);
    {en, wr, bt, a, d} = {1'b1, w, b, ad, dd};
    @(negedge clk);
  endtask
  // released lines flip so a stale value never looks live
  task automatic idle();
    {en, a, d} = {1'b0, ~a, ~d};
  endtask
endmodule // dpr_dma_mdl
`default_nettype wire

// ==== testbench/dual_port_dma_ram_tb.sv ====
// self-checking bench for the dual-ported ram block
// assumes dpr_top, its checker and the dma model compile first
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// bench
module dual_port_dma_ram_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, cpu_en = 1'b0, cpu_wr = 1'b0;
  logic cpu_byte = 1'b0, dma_en, dma_wr, dma_byte, cpu_rvld, dma_rvld;
  logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
  logic [15:0] dma_addr, dma_wdata, cpu_rdata, dma_rdata;
  int bad_count = 0, comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  dpr_top dut_u (.*);
  dpr_dma_mdl mdl_u (.clk(ref_clk), .en(dma_en), .wr(dma_wr),
    .bt(dma_byte), .a(dma_addr), .d(dma_wdata));
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic idle(input bit p);
    if (p) mdl_u.idle();
    else {cpu_en, cpu_addr, cpu_wdata} = {1'b0, ~cpu_addr, ~cpu_wdata};
  endtask
  task automatic wr(input bit p, input logic b, input logic [15:0] a, d);
    if (p) mdl_u.put(1'b1, b, a, d);
    else begin
      {cpu_en, cpu_wr, cpu_byte, cpu_addr, cpu_wdata} = {2'b11, b, a, d};
      @(negedge ref_clk);
    end
  endtask
  task automatic rd(input bit p, input logic b, input logic [15:0] a, e);
    if (p) mdl_u.put(1'b0, b, a, ~a);
    else begin
      {cpu_en, cpu_wr, cpu_byte, cpu_addr} = {2'b10, b, a};
      @(negedge ref_clk);
    end
    idle(p);
    @(negedge ref_clk);
    chk(p ? dma_rvld : cpu_rvld, 16'h0001);
    chk(p ? dma_rdata : cpu_rdata, e);
  endtask
  task automatic t_word();
    wr(0, 1'b0, 16'h0002, 16'hA5C3);
    idle(0);
    rd(1, 1'b0, 16'hF802, 16'hA5C3);
    wr(1, 1'b0, 16'h07FE, 16'h1234);
    rd(1, 1'b0, 16'h07FE, 16'h1234);
    rd(0, 1'b0, 16'h07FE, 16'h1234);
    $display("word test done");
  endtask
  task automatic t_byte();
    wr(0, 1'b0, 16'h0010, 16'h1111);
    idle(0);
    wr(1, 1'b1, 16'h0011, 16'h00AB);
    wr(1, 1'b1, 16'h0010, 16'hFF77);
    idle(1);
    rd(0, 1'b1, 16'h0011, 16'h00AB);
    rd(1, 1'b0, 16'h0010, 16'hAB77);
    wr(0, 1'b1, 16'h0011, 16'h00CD);
    idle(0);
    rd(1, 1'b1, 16'h0010, 16'h0077);
    rd(0, 1'b0, 16'h0010, 16'hCD77);
    $display("byte test done");
  endtask
  task automatic t_clash();
    fork
      wr(0, 1'b0, 16'h0020, 16'hBEEF);
      wr(1, 1'b0, 16'h0020, 16'h0BAD);
    join
    idle(1);
    rd(0, 1'b0, 16'h0020, 16'hBEEF);
    fork
      wr(0, 1'b1, 16'h0030, 16'h0011);
      wr(1, 1'b0, 16'h0030, 16'h2233);
    join
    idle(0);
    idle(1);
    fork
      rd(0, 1'b0, 16'h0030, 16'h2211);
      rd(1, 1'b1, 16'h0031, 16'h0022);
    join
    $display("clash test done");
  endtask
  task automatic t_reset();
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk(cpu_rvld, 16'h0000);
    chk(cpu_rdata, 16'h0000);
    chk(dma_rvld, 16'h0000);
    chk(dma_rdata, 16'h0000);
    rst_n = 1'b1;
    rd(0, 1'b0, 16'h0030, 16'h2211);
    $display("reset test done");
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    t_word();
    t_byte();
    t_clash();
    t_reset();
    give_verdict();
  end
  // about 35 cycles of traffic; over eleven times that before giving up
  initial begin
    #2000;
    bad_count++;
    give_verdict();
  end
endmodule // dual_port_dma_ram_tb
`default_nettype wire
